// >>> hdl/vid_consts.svh
// register map, field positions, reset values and timing limits of the video source
`ifndef VID_CONSTS_SVH
`define VID_CONSTS_SVH

`define REG_CTRL        8'h00
`define REG_HACT        8'h04
`define REG_VACT        8'h08
`define REG_HSW         8'h0C
`define REG_HBP         8'h10
`define REG_HFP         8'h14
`define REG_VSW         8'h18
`define REG_VBP         8'h1C
`define REG_VFP         8'h20
`define REG_PIXDATA     8'h24
`define REG_STATUS      8'h28

`define CTRL_EN         0
`define CTRL_REP        1
`define CTRL_LANE_LSB   2
`define CTRL_BMODE_LSB  4
`define CTRL_ANALOG     6
`define CTRL_CVT        7

`define ST_RUN_BIT      0
`define ST_CFGOK_BIT    1
`define ST_UNDER_BIT    2
`define ST_FULL_BIT     3
`define ST_FRAMES_LSB   16

`define RST_CTRL        8'h00
`define RST_HACT        16'h0280
`define RST_VACT        16'h01E0
`define RST_HSW         16'h0010
`define RST_HBP         16'h0040
`define RST_HFP         16'h0010
`define RST_VSW         16'h0004
`define RST_VBP         16'h0010
`define RST_VFP         16'h000A

`define VSW_MIN         32'h00000001
`define VSW_MAX         32'h0000007F
`define VBP_MIN         32'h00000002
`define VFP_FLOOR       32'h00000001
`define TVB_BASE        32'h0000000B
`define TVB_SLOPE       32'h00000016
`define TVB_NATIVE      32'h00000438
`define TVB_OFFSET      32'h00000041
`define TVB_CVT         32'h00000017
`define HSW_MIN         32'h00000010
`define HBP_MIN_DIG     32'h00000005
`define HBP_MIN_ANA     32'h00000041
`define HFP_MIN         32'h00000002
`define THB_MIN_DIG     32'h00000014
`define THB_MIN_ANA     32'h00000050
`define HACT_MIN        32'h00000280
`define HACT_MAX        32'h00001000
`define VACT_MIN        32'h000001E0
`define VACT_MAX        32'h00000870
`define BMODE_MAX       2'h2

`endif

// >>> hdl/vid_pkg.sv
// types shared by the video source modules
package vid_pkg;
  typedef logic [15:0] span_t;
  typedef logic [1:0]  lane_t;
  typedef logic [1:0]  bmode_t;
  typedef enum logic {ST_IDLE, ST_RUN} gen_state_e;
  typedef struct packed {
    span_t  hact;
    span_t  vact;
    span_t  hsw;
    span_t  hbp;
    span_t  hfp;
    span_t  vsw;
    span_t  vbp;
    span_t  vfp;
    logic   rep;
    lane_t  lanes;
    bmode_t bmode;
  } cfg_s;
endpackage

// >>> hdl/pix_stream_if.sv
// valid/ready word stream between the register side, the fifo and the generator
`timescale 1ns/1ps
interface pix_stream_if #(parameter int W = 32) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> hdl/span_counter.sv
// wrapping position counter used for pixel and line positions
`timescale 1ns/1ps
module span_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         clear,
  input  wire logic         adv,
  input  wire logic [W-1:0] total,
  output logic      [W-1:0] cnt_ff,
  output logic              wrap
);
  assign wrap = adv && (cnt_ff == W'(total - W'(1)));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (clear || wrap) begin
      cnt_ff <= '0;
    end else if (adv) begin
      cnt_ff <= W'(cnt_ff + W'(1));
    end
  end
endmodule

// >>> hdl/pix_fifo.sv
// pixel word fifo: DEPTH words in memory plus a registered output word
`timescale 1ns/1ps
module pix_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input  wire logic   clk,
  input  wire logic   rst_n,
  pix_stream_if.snk   wr,
  pix_stream_if.src   rd
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wptr_ff;
  logic [AW-1:0]    rptr_ff;
  logic [AW:0]      cnt_ff;
  logic [WIDTH-1:0] out_ff;
  logic             ovalid_ff;

  wire push = wr.valid && wr.ready;
  wire load = (cnt_ff != '0) && (!ovalid_ff || rd.ready);

  assign wr.ready = (cnt_ff != (AW+1)'(DEPTH));
  assign rd.valid = ovalid_ff;
  assign rd.data  = out_ff;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_ff[wptr_ff] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_ff   <= '0;
      rptr_ff   <= '0;
      cnt_ff    <= '0;
      out_ff    <= '0;
      ovalid_ff <= 1'b0;
    end else begin
      wptr_ff <= push ? AW'(wptr_ff + AW'(1)) : wptr_ff;
      rptr_ff <= load ? AW'(rptr_ff + AW'(1)) : rptr_ff;
      cnt_ff  <= (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(load));
      if (load) begin
        out_ff    <= mem_ff[rptr_ff];
        ovalid_ff <= 1'b1;
      end else if (rd.ready) begin
        ovalid_ff <= 1'b0;
      end
    end
  end
endmodule

// >>> hdl/video_source.sv
// video source: frame timing generator with pixel fifo, configured over AXI4-Lite
// Functional notes
// [R1] receiver takes one, two, four or eight lanes and 3/4/5-byte modes
// [R2] vertical sync lasts between 1 and 127 lines
// [R3] vertical back porch, sync included, is at least 2 lines
// [R4] vertical front porch is at least max(minimum blanking minus 65, 1)
// [R5] total vertical blanking at least 11 + ceil(22 * active lines / 1080)
// [R6] standard-timing sources should use at least 23 blanking lines
// [R7] receiver accepts any porch split meeting each porch minimum
// [R8] horizontal sync lasts at least 16 pixel clocks
// [R9] horizontal back porch, sync included, at least 5 digital or 65 analog
// [R10] horizontal front porch is at least 2 pixel clocks
// [R11] total horizontal blanking at least 20 digital or 80 analog clocks
// [R12] active pixels per line between 640 and 4096
// [R13] active lines per frame between 480 and 2160
// [R14] pixel repeat sends every pixel and blanking clock twice
// [R15] receiver drops the duplicates in pixel-repeat mode
// [R16] pixel repeat only with a single lane
// [R17] receiver counts active pixels and lines to check the limits
//
// The placing of the registers and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
`include "vid_consts.svh"
module video_source #(
  parameter int FIFO_DEPTH = 32,
  parameter int PIX_W      = 32
) (
  input  wire logic           CORE_CLK,
  input  wire logic           RESET_N,
  input  wire logic [7:0]     AWADDR,
  input  wire logic           AWVALID,
  output logic                AWREADY,
  input  wire logic [31:0]    WDATA,
  input  wire logic [3:0]     WSTRB,
  input  wire logic           WVALID,
  output logic                WREADY,
  output logic [1:0]          BRESP,
  output logic                BVALID,
  input  wire logic           BREADY,
  input  wire logic [7:0]     ARADDR,
  input  wire logic           ARVALID,
  output logic                ARREADY,
  output logic [31:0]         RDATA,
  output logic [1:0]          RRESP,
  output logic                RVALID,
  input  wire logic           RREADY,
  output logic                HSYNC,
  output logic                VSYNC,
  output logic                ACTIVE_VIDEO_QUALIFIER,
  output logic [PIX_W-1:0]    PIXEL,
  output vid_pkg::lane_t      LANE_CODE,
  output vid_pkg::bmode_t     BYTE_MODE,
  output logic                PIXEL_REPEAT
);
  import vid_pkg::*;

  function automatic logic mapped(input logic [7:0] a);
    if (a == `REG_CTRL || a == `REG_HACT || a == `REG_VACT) begin
      return 1'b1;
    end else if (a == `REG_HSW || a == `REG_HBP || a == `REG_HFP) begin
      return 1'b1;
    end else if (a == `REG_VSW || a == `REG_VBP || a == `REG_VFP) begin
      return 1'b1;
    end else if (a == `REG_PIXDATA || a == `REG_STATUS) begin
      return 1'b1;
    end else begin
      return 1'b0;
    end
  endfunction

  function automatic logic [31:0] tvb_min(input span_t lines);
    return `TVB_BASE + ((`TVB_SLOPE * 32'(lines) + `TVB_NATIVE - 32'h1) / `TVB_NATIVE);
  endfunction

  function automatic span_t merge16(input span_t old, input logic [31:0] d,
                                    input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  pix_stream_if #(.W(PIX_W)) in_s ();
  pix_stream_if #(.W(PIX_W)) out_s ();

  pix_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) fifo_u (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .wr    (in_s.snk),
    .rd    (out_s.src)
  );

  logic [7:0]  ctrl_ff;
  span_t       hact_ff, vact_ff, hsw_ff, hbp_ff, hfp_ff, vsw_ff, vbp_ff, vfp_ff;
  cfg_s        sh_ff;
  gen_state_e  state_ff;
  logic        phase_ff;
  logic        under_ff;
  logic [15:0] frames_ff;
  logic        hs_ff, vs_ff, de_ff;
  logic [PIX_W-1:0] pix_ff;
  logic        awready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]  bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;

  // register side: write address and data are taken together in one cycle
  wire         wr_go   = AWVALID && WVALID && !awready_ff && !bvalid_ff &&
                         (AWADDR != `REG_PIXDATA || in_s.ready);
  wire         wr_fire = awready_ff;
  wire         rd_go   = ARVALID && !arready_ff && !rvalid_ff;
  wire         push    = wr_fire && (AWADDR == `REG_PIXDATA);

  // pixel words go into the fifo; a full fifo holds off AWREADY/WREADY
  assign in_s.valid = push;
  assign in_s.data  = WDATA[PIX_W-1:0];

  // live configuration checks against the source frame limits
  wire         analog   = ctrl_ff[`CTRL_ANALOG];
  wire [31:0]  tvb_live = tvb_min(vact_ff);
  wire [31:0]  vfp_need = (tvb_live > `TVB_OFFSET + `VFP_FLOOR) ? tvb_live - `TVB_OFFSET
                                                               : `VFP_FLOOR;
  wire [31:0]  tvb_have = 32'(vbp_ff) + 32'(vfp_ff);
  wire [31:0]  thb_have = 32'(hbp_ff) + 32'(hfp_ff);
  wire         v_ok = (32'(vsw_ff) >= `VSW_MIN) && (32'(vsw_ff) <= `VSW_MAX) && // [R2]
                      (32'(vbp_ff) >= `VBP_MIN) && (vbp_ff > vsw_ff) &&        // [R3]
                      (32'(vfp_ff) >= vfp_need) &&                             // [R4]
                      (tvb_have >= tvb_live) &&                                // [R5]
                      (!ctrl_ff[`CTRL_CVT] || tvb_have >= `TVB_CVT);           // [R6]
  wire         h_ok = (32'(hsw_ff) >= `HSW_MIN) && (hbp_ff > hsw_ff) &&        // [R8]
                      (32'(hbp_ff) >= (analog ? `HBP_MIN_ANA : `HBP_MIN_DIG)) && // [R9]
                      (32'(hfp_ff) >= `HFP_MIN) &&                             // [R10]
                      (thb_have >= (analog ? `THB_MIN_ANA : `THB_MIN_DIG));    // [R11]
  wire         a_ok = (32'(hact_ff) >= `HACT_MIN) && (32'(hact_ff) <= `HACT_MAX) && // [R12]
                      (32'(vact_ff) >= `VACT_MIN) && (32'(vact_ff) <= `VACT_MAX);   // [R13]
  wire         m_ok = (ctrl_ff[`CTRL_BMODE_LSB+:2] <= `BMODE_MAX) &&           // [R1]
                      (!ctrl_ff[`CTRL_REP] || ctrl_ff[`CTRL_LANE_LSB+:2] == 2'h0); // [R16]
  wire         cfg_ok = v_ok && h_ok && a_ok && m_ok;
  wire         start  = ctrl_ff[`CTRL_EN] && cfg_ok;

  wire cfg_s   live_cfg = '{hact: hact_ff, vact: vact_ff, hsw: hsw_ff, hbp: hbp_ff,
                            hfp: hfp_ff, vsw: vsw_ff, vbp: vbp_ff, vfp: vfp_ff,
                            rep: ctrl_ff[`CTRL_REP], lanes: ctrl_ff[`CTRL_LANE_LSB+:2],
                            bmode: ctrl_ff[`CTRL_BMODE_LSB+:2]};

  // frame generator; in repeat mode every position is held for two clocks
  wire         running = (state_ff == ST_RUN);
  wire         adv     = running && (!sh_ff.rep || phase_ff); // [R14]
  wire span_t  htot    = span_t'(sh_ff.hbp + sh_ff.hact + sh_ff.hfp);
  wire span_t  vtot    = span_t'(sh_ff.vbp + sh_ff.vact + sh_ff.vfp);
  span_t       hc, vc;
  wire         h_wrap, v_wrap;

  span_counter #(.W(16)) h_cnt_u (
    .clk    (CORE_CLK),
    .rst_n  (RESET_N),
    .clear  (!running),
    .adv    (adv),
    .total  (htot),
    .cnt_ff (hc),
    .wrap   (h_wrap)
  );

  span_counter #(.W(16)) v_cnt_u (
    .clk    (CORE_CLK),
    .rst_n  (RESET_N),
    .clear  (!running),
    .adv    (h_wrap),
    .total  (vtot),
    .cnt_ff (vc),
    .wrap   (v_wrap)
  );

  // sync leading edges sit at position zero, back porches include the sync pulse
  wire         hs_n  = hc < sh_ff.hsw;                                          // [R8]
  wire         vs_n  = vc < sh_ff.vsw;                                          // [R2]
  wire         de_n  = (hc >= sh_ff.hbp) && (hc < span_t'(sh_ff.hbp + sh_ff.hact)) &&
                       (vc >= sh_ff.vbp) && (vc < span_t'(sh_ff.vbp + sh_ff.vact)); // [R9]
  wire         frame_end = v_wrap;
  wire         starve    = adv && de_n && !out_s.valid;
  wire         clr_under = wr_fire && (AWADDR == `REG_STATUS) && WSTRB[0] &&
                           WDATA[`ST_UNDER_BIT];
  assign out_s.ready = adv && de_n;

  wire [31:0]  status_w = {frames_ff, 12'h000, !in_s.ready, under_ff, cfg_ok, running};
  wire [31:0]  rd_mux =
    (ARADDR == `REG_CTRL)   ? {24'h000000, ctrl_ff} :
    (ARADDR == `REG_HACT)   ? {16'h0000, hact_ff} :
    (ARADDR == `REG_VACT)   ? {16'h0000, vact_ff} :
    (ARADDR == `REG_HSW)    ? {16'h0000, hsw_ff} :
    (ARADDR == `REG_HBP)    ? {16'h0000, hbp_ff} :
    (ARADDR == `REG_HFP)    ? {16'h0000, hfp_ff} :
    (ARADDR == `REG_VSW)    ? {16'h0000, vsw_ff} :
    (ARADDR == `REG_VBP)    ? {16'h0000, vbp_ff} :
    (ARADDR == `REG_VFP)    ? {16'h0000, vfp_ff} :
    (ARADDR == `REG_STATUS) ? status_w : 32'h00000000;

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      awready_ff <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= 2'h0;
      rdata_ff   <= 32'h00000000;
    end else begin
      awready_ff <= wr_go;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= mapped(AWADDR) ? 2'h0 : 2'h2;
      end else if (BREADY) begin
        bvalid_ff <= 1'b0;
      end
      arready_ff <= rd_go;
      if (arready_ff) begin
        rvalid_ff <= 1'b1;
        rdata_ff  <= rd_mux;
        rresp_ff  <= mapped(ARADDR) ? 2'h0 : 2'h2;
      end else if (RREADY) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_ff <= `RST_CTRL;
      hact_ff <= `RST_HACT;
      vact_ff <= `RST_VACT;
      hsw_ff  <= `RST_HSW;
      hbp_ff  <= `RST_HBP;
      hfp_ff  <= `RST_HFP;
      vsw_ff  <= `RST_VSW;
      vbp_ff  <= `RST_VBP;
      vfp_ff  <= `RST_VFP;
    end else if (wr_fire) begin
      if (AWADDR == `REG_CTRL && WSTRB[0]) begin
        ctrl_ff <= WDATA[7:0];
      end else if (AWADDR == `REG_HACT) begin
        hact_ff <= merge16(hact_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_VACT) begin
        vact_ff <= merge16(vact_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_HSW) begin
        hsw_ff <= merge16(hsw_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_HBP) begin
        hbp_ff <= merge16(hbp_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_HFP) begin
        hfp_ff <= merge16(hfp_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_VSW) begin
        vsw_ff <= merge16(vsw_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_VBP) begin
        vbp_ff <= merge16(vbp_ff, WDATA, WSTRB);
      end else if (AWADDR == `REG_VFP) begin
        vfp_ff <= merge16(vfp_ff, WDATA, WSTRB);
      end
    end
  end

  // the frame shape is latched only at a frame boundary
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff  <= ST_IDLE;
      sh_ff     <= '0;
      phase_ff  <= 1'b0;
      frames_ff <= 16'h0000;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          phase_ff <= 1'b0;
          if (start) begin
            state_ff <= ST_RUN;
            sh_ff    <= live_cfg;
          end
        end
        ST_RUN: begin
          phase_ff <= sh_ff.rep ? !phase_ff : 1'b0; // [R14]
          if (frame_end) begin
            frames_ff <= 16'(frames_ff + 16'h0001);
            sh_ff     <= live_cfg;
            state_ff  <= start ? ST_RUN : ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      hs_ff    <= 1'b0;
      vs_ff    <= 1'b0;
      de_ff    <= 1'b0;
      pix_ff   <= '0;
      under_ff <= 1'b0;
    end else begin
      if (!running) begin
        hs_ff  <= 1'b0;
        vs_ff  <= 1'b0;
        de_ff  <= 1'b0;
        pix_ff <= '0;
      end else if (adv) begin
        hs_ff  <= hs_n;
        vs_ff  <= vs_n;
        de_ff  <= de_n;
        pix_ff <= (de_n && out_s.valid) ? out_s.data : '0;
      end
      under_ff <= starve || (under_ff && !clr_under);
    end
  end

  assign AWREADY = awready_ff;
  assign WREADY  = awready_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID  = rvalid_ff;
  assign RRESP   = rresp_ff;
  assign RDATA   = rdata_ff;
  assign HSYNC   = hs_ff;
  assign VSYNC   = vs_ff;
  assign ACTIVE_VIDEO_QUALIFIER = de_ff;
  assign PIXEL   = pix_ff;
  assign LANE_CODE    = sh_ff.lanes;
  assign BYTE_MODE    = sh_ff.bmode;
  assign PIXEL_REPEAT = sh_ff.rep;

  // helper counts of what the receiver would measure
  logic [15:0] de_cyc_ff, act_lines_ff, vs_lines_ff, hs_cyc_ff;
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      de_cyc_ff    <= 16'h0000;
      act_lines_ff <= 16'h0000;
      vs_lines_ff  <= 16'h0000;
      hs_cyc_ff    <= 16'h0000;
    end else begin
      de_cyc_ff    <= de_ff ? 16'(de_cyc_ff + 16'h0001) : 16'h0000;
      hs_cyc_ff    <= hs_ff ? 16'(hs_cyc_ff + 16'h0001) : 16'h0000;
      act_lines_ff <= (vs_ff && !$past(vs_ff)) ? 16'h0000 :
                      (de_ff && !$past(de_ff)) ? 16'(act_lines_ff + 16'h0001) : act_lines_ff;
      vs_lines_ff  <= !vs_ff ? 16'h0000 :
                      (hs_ff && !$past(hs_ff)) ? 16'(vs_lines_ff + 16'h0001) : vs_lines_ff;
    end
  end
  wire [31:0] rep_mul = PIXEL_REPEAT ? 32'h2 : 32'h1;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  a_hsync_width: // [R8]
    assert property ($fell(HSYNC) |-> 32'(hs_cyc_ff) >= `HSW_MIN * rep_mul)
      else $error("hsync shorter than 16");
  a_hbp_min: // [R9]
    assert property ($rose(HSYNC) |-> !ACTIVE_VIDEO_QUALIFIER[*5])
      else $error("back porch too short");
  a_hfp_min: // [R10]
    assert property ($fell(ACTIVE_VIDEO_QUALIFIER) |-> !HSYNC[*2])
      else $error("front porch too short");
  a_vsync_lines: // [R2]
    assert property ($rose(HSYNC) && VSYNC |-> vs_lines_ff < 16'h007F)
      else $error("vsync longer than 127 lines");
  a_hact_range: // [R12]
    assert property ($fell(ACTIVE_VIDEO_QUALIFIER) |->
                     32'(de_cyc_ff) >= `HACT_MIN * rep_mul &&
                     32'(de_cyc_ff) <= `HACT_MAX * rep_mul)
      else $error("active width out of range");
  a_vact_range: // [R13]
    assert property ($rose(VSYNC) && act_lines_ff != 16'h0000 |->
                     32'(act_lines_ff) >= `VACT_MIN && 32'(act_lines_ff) <= `VACT_MAX)
      else $error("active height out of range");
  a_repeat_hold: // [R14]
    assert property (running && sh_ff.rep && !adv |=>
                     $stable(HSYNC) && $stable(VSYNC) && $stable(PIXEL) &&
                     $stable(ACTIVE_VIDEO_QUALIFIER))
      else $error("repeated clock changed the output");
  a_repeat_lane: // [R16]
    assert property (PIXEL_REPEAT |-> LANE_CODE == 2'h0) else $error("repeat with lanes");
  a_run_blanking: // [R5]
    assert property (running |-> 32'(sh_ff.vbp) + 32'(sh_ff.vfp) >= tvb_min(sh_ff.vact) &&
                     32'(sh_ff.vbp) >= `VBP_MIN)
      else $error("vertical blanking below minimum");

  c_frame_done:   cover property (frame_end);
  c_repeat_frame: cover property (frame_end && sh_ff.rep);
  c_underrun:     cover property (starve);
  c_fifo_full:    cover property (AWVALID && WVALID && !in_s.ready);
endmodule

// >>> test/vid_rx_model.sv
// receiver-side model: drops repeats, measures line timing, captures pixels
`timescale 1ns/1ps
module vid_rx_model (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hs,
  input wire logic        de,
  input wire logic [31:0] pix,
  input wire logic [1:0]  lanes,
  input wire logic [1:0]  bmode,
  input wire logic        rep
);
  int          hsw, hbp, act, lines, run, hpos, viol;
  logic [31:0] got[$];
  logic        hs_q, de_q, hs_raw, take;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {hsw, hbp, act, lines, run, hpos, viol} = '0;
      {hs_q, de_q, hs_raw, take} = '0;
      got.delete();
    end else begin
      // every second clock of a pair is a duplicate; pairs start at sync rise
      take = !rep || (hs && !hs_raw) || !take;
      hs_raw = hs;
      if ((rep && lanes != 2'h0) || bmode == 2'h3) viol++;
      if (take) begin
        hpos = (hs && !hs_q) ? 0 : hpos + 1;
        if (!hs && hs_q) hsw = hpos;
        if (de && !de_q) begin
          hbp = hpos;
          lines++;
          run = 0;
        end
        if (de) begin
          run++;
          got.push_back(pix);
        end
        if (!de && de_q) begin
          act = run;
          // only the sync and back porch minimums and the active width are judged, any split is accepted
          if (hsw < 16 || hbp < 5 || act < 640 || act > 4096) viol++;
        end
        hs_q = hs;
        de_q = de;
      end
    end
  end
endmodule

// >>> test/source_frame_timing_intake_tb.sv
// self-checking bench for the video source: registers, fifo, line timing, repeat
`timescale 1ns/1ps
`include "vid_consts.svh"
module source_frame_timing_intake_tb;
  logic        CORE_CLK = 1'b0, RESET_N = 1'b0;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, PIXEL;
  logic [3:0]  WSTRB = 4'hF;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, PIXEL_REPEAT;
  logic        HSYNC, VSYNC, ACTIVE_VIDEO_QUALIFIER;
  logic [1:0]  BRESP, RRESP, LANE_CODE, BYTE_MODE;
  int          errors = 0, checked = 0;

  video_source #(.FIFO_DEPTH(32), .PIX_W(32)) video_source_inst (.*);
  vid_rx_model rx (.clk(CORE_CLK), .rst_n(RESET_N), .hs(HSYNC), .de(ACTIVE_VIDEO_QUALIFIER),
    .pix(PIXEL), .lanes(LANE_CODE), .bmode(BYTE_MODE), .rep(PIXEL_REPEAT));

  always #4 CORE_CLK = ~CORE_CLK;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do @(posedge CORE_CLK); while (AWREADY !== 1'b1);
    AWVALID <= 1'b0;
    WVALID <= 1'b0;
    do @(posedge CORE_CLK); while (BVALID !== 1'b1);
    r = BRESP;
    BREADY <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk(r, 32'h0);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do @(posedge CORE_CLK); while (ARREADY !== 1'b1);
    ARVALID <= 1'b0;
    do @(posedge CORE_CLK); while (RVALID !== 1'b1);
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d & m, e);
  endtask
  task automatic rst();
    RESET_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    @(posedge CORE_CLK);
  endtask
  task automatic cfg_case(input logic [7:0] a, input logic [15:0] bad, input logic [15:0] good);
    w(a, {16'h0, bad});
    rchk(`REG_STATUS, 32'h2, 32'h0);
    w(a, {16'h0, good});
    rchk(`REG_STATUS, 32'h2, 32'h2);
  endtask

  task automatic t_regs();
    logic [15:0] rv[9];
    logic [31:0] d;
    logic [1:0]  r;
    rv = '{`RST_CTRL, `RST_HACT, `RST_VACT, `RST_HSW, `RST_HBP, `RST_HFP, `RST_VSW, `RST_VBP,
           `RST_VFP};
    for (int i = 0; i < 9; i++) rchk(8'(i * 4), 32'hFFFFFFFF, {16'h0, rv[i]});
    chk({HSYNC, VSYNC, ACTIVE_VIDEO_QUALIFIER, PIXEL_REPEAT}, 32'h0);
    rchk(`REG_STATUS, 32'hF, 32'h2);
    rd(8'h2C, d, r);
    chk({d[29:0], r}, 32'h2);
    wr(8'h30, 32'h1, r);
    chk(r, 32'h2);
  endtask
  task automatic t_cfg();
    w(`REG_VFP, 32'h20);
    cfg_case(`REG_VSW, 16'h0, 16'h1);
    cfg_case(`REG_VBP, 16'h1, 16'h2);
    w(`REG_VBP, 32'h20);
    cfg_case(`REG_VFP, 16'h0, 16'h1);
    w(`REG_VBP, 32'h10);
    cfg_case(`REG_VFP, 16'h4, 16'h5);
    cfg_case(`REG_HSW, 16'hF, 16'h10);
    cfg_case(`REG_HFP, 16'h1, 16'h2);
    w(`REG_HBP, 32'h11);
    cfg_case(`REG_HFP, 16'h2, 16'h3);
    w(`REG_HFP, 32'h10);
    w(`REG_CTRL, 32'h40);
    cfg_case(`REG_HBP, 16'h40, 16'h41);
    w(`REG_CTRL, 32'h80);
    cfg_case(`REG_VFP, 16'h6, 16'h7);
    w(`REG_CTRL, 32'h0);
    cfg_case(`REG_HACT, 16'h27F, 16'h1000);
    cfg_case(`REG_HACT, 16'h1001, 16'h280);
    w(`REG_VFP, 32'h40);
    cfg_case(`REG_VACT, 16'h871, 16'h870);
    cfg_case(`REG_VACT, 16'h1DF, 16'h1E0);
  endtask
  task automatic t_video();
    for (int i = 0; i < 33; i++) w(`REG_PIXDATA, 32'hA5000000 + i);
    rchk(`REG_STATUS, 32'h8, 32'h8);
    w(`REG_CTRL, 32'h1);
    while (rx.lines < 2) @(posedge CORE_CLK);
    chk(rx.hsw, 32'h10);
    chk(rx.hbp, 32'h41);
    chk(rx.act, 32'h280);
    for (int i = 0; i < 34; i++) chk(rx.got[i], i < 33 ? 32'hA5000000 + i : 32'h0);
    rchk(`REG_STATUS, 32'hD, 32'h5);
  endtask
  task automatic t_modes();
    for (int k = 0; k < 4; k++) begin
      rst();
      w(`REG_CTRL, 32'h1 | (k << 2) | ((k % 3) << 4));
      while (HSYNC !== 1'b1) @(posedge CORE_CLK);
      chk({LANE_CODE, BYTE_MODE, PIXEL_REPEAT}, 32'((k << 3) | ((k % 3) << 1)));
    end
  endtask
  task automatic t_repeat();
    rst();
    w(`REG_CTRL, 32'h3);
    while (rx.lines < 2) @(posedge CORE_CLK);
    chk(rx.hsw, 32'h10);
    chk(rx.hbp, 32'h40);
    chk(rx.act, 32'h280);
    chk(PIXEL_REPEAT, 32'h1);
    chk(rx.viol, 32'h0);
  endtask

  task automatic results();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    rst();
    t_regs();
    t_cfg();
    t_video();
    t_modes();
    t_repeat();
    results();
  end
  // all scenarios need about 38000 cycles
  initial begin
    repeat (70000) @(posedge CORE_CLK);
    errors++;
    results();
  end
endmodule
